// ==== design/jbs_pkg.sv ====
// constants, types and register map of the scan and programming port
// assumes one hclk domain; the scan pins arrive asynchronously
package jbs_pkg;
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_USERCODE = 4'h3;
  localparam logic [3:0] IR_SIGN = 4'h4;
  localparam logic [3:0] IR_PRG_ENTER = 4'h5;
  localparam logic [3:0] IR_PRG_ADAPT = 4'h6;
  localparam logic [3:0] IR_PRG_CONST = 4'h7;
  localparam logic [3:0] IR_PRG_VERIFY = 4'h8;
  localparam logic [3:0] IR_PRG_DONE = 4'h9;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_STAT = 32'h0000_0004;
  localparam logic [31:0] OFS_CONF = 32'h0000_0008;
  localparam logic [31:0] OFS_IDR = 32'h0000_000C;
  localparam int CTRL_USER_IO = 0;
  localparam int CTRL_TDO_VAL = 1;
  localparam int CTRL_TDO_OE = 2;
  localparam int STAT_DONE = 0;
  localparam int STAT_PRG = 1;
  localparam int STAT_PINS = 2;
  localparam int STAT_IR = 8;
  localparam int STAT_TAP = 12;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic DONE_RST = 1'b1;
  localparam logic [31:0] CONF_RST = 32'h0000_0000;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jbs_tap_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jbs_scan_t;
endpackage : jbs_pkg

// ==== design/jbs_port.sv ====
// scan test and in-system programming port, with ahb-lite registers
// assumes scan pins async to hclk; tck much slower than hclk
//
// What this block does
// (R1) programming runs only through four-wire scan port
// (R2) programming: all user pins off, weak pull-up
// (R3) enhanced only: no pin drives until completion flag set, except under external test
// (R4) adaptive method reads back, then adapts steps
// (R5) constant method uses fixed sequence, no readback
// (R6) enhanced: both methods; base: adaptive only
// (R7) sample/preload snapshots pins, preloads output pattern
// (R8) external test drives pattern, captures input pins
// (R9) bypass puts one bit between tdi and tdo
// (R10) identification register shifts out on tdo
// (R11) enhanced only: 32-bit user code shifts out
// (R12) base only: user signature shifts out
// (R13) dedicated instructions program the configuration
// (R14) scan pins usable as plain user pins
// (R15) sixteen-state controller, lsb-first shifting
// (R16) unknown instruction codes select bypass
module jbs_port #(
  parameter int NPIN = 8,
  parameter bit ENHANCED = 1'b1,
  parameter logic [31:0] IDCODE_VAL = 32'h0A5C_3001 // arbitrary value
) (
  // system
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // scan port pins
  input wire jbs_pkg::jbs_scan_t scan_in,
  output logic tdo_out,
  output logic tdo_oe,
  // user pins and core logic
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] core_out,
  input wire logic [NPIN-1:0] core_oe,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic [NPIN-1:0] pin_pullup
);
  import jbs_pkg::*;
  localparam int BW = 3 * NPIN;
  localparam int SW = (BW > 32) ? BW : 32;

  jbs_scan_t scan_s1_reg, scan_s2_reg;
  logic tck_d_reg;
  logic [NPIN-1:0] pin_s1_reg, pin_s2_reg;
  jbs_tap_t tap_reg;
  logic [3:0] ir_sr_reg, ir_reg;
  logic [SW-1:0] dr_sr_reg, dr_cap, dr_sh;
  logic [BW-1:0] bsr_reg;
  logic [31:0] conf_reg;
  logic prog_done_reg;
  logic [2:0] ctrl_reg;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic tdo_reg, tdo_oe_reg;
  logic [NPIN-1:0] pin_out_reg, pin_oe_reg, pin_pu_reg;
  logic [NPIN-1:0] pin_out_next, pin_oe_next, pin_pu_next;

  function automatic jbs_tap_t tap_step(jbs_tap_t s, logic m);
    case (s)
      TLR: return m ? TLR : RTI;
      RTI: return m ? SEL_DR : RTI;
      SEL_DR: return m ? SEL_IR : CAP_DR;
      CAP_DR: return m ? EX1_DR : SH_DR;
      SH_DR: return m ? EX1_DR : SH_DR;
      EX1_DR: return m ? UPD_DR : PA_DR;
      PA_DR: return m ? EX2_DR : PA_DR;
      EX2_DR: return m ? UPD_DR : SH_DR;
      UPD_DR: return m ? SEL_DR : RTI;
      SEL_IR: return m ? TLR : CAP_IR;
      CAP_IR: return m ? EX1_IR : SH_IR;
      SH_IR: return m ? EX1_IR : SH_IR;
      EX1_IR: return m ? UPD_IR : PA_IR;
      PA_IR: return m ? EX2_IR : PA_IR;
      EX2_IR: return m ? UPD_IR : SH_IR;
      UPD_IR: return m ? SEL_DR : RTI;
      default: return TLR;
    endcase
  endfunction : tap_step

  function automatic int dr_len(logic [3:0] ir);
    if (ir == IR_BYPASS) return 1;
    if (ir == IR_EXTEST || ir == IR_SAMPLE) return BW;
    return 32;
  endfunction : dr_len

  // edge detection reads the second stage only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_s1_reg <= '0;
      scan_s2_reg <= '0;
      tck_d_reg <= 1'b0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      scan_s1_reg <= scan_in;
      scan_s2_reg <= scan_s1_reg;
      tck_d_reg <= scan_s2_reg.tck;
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire tck_rise = scan_s2_reg.tck & ~tck_d_reg;
  wire tck_fall = ~scan_s2_reg.tck & tck_d_reg;
  wire tdi = scan_s2_reg.tdi;
  wire user_io = ctrl_reg[CTRL_USER_IO];

  // instruction decode; variant-specific codes fall back to bypass
  wire ir_common = ir_reg == IR_EXTEST || ir_reg == IR_SAMPLE ||
    ir_reg == IR_IDCODE || ir_reg == IR_BYPASS ||
    ir_reg == IR_PRG_ENTER || ir_reg == IR_PRG_ADAPT ||
    ir_reg == IR_PRG_VERIFY;
  wire ir_enh = ir_reg == IR_USERCODE || ir_reg == IR_PRG_CONST ||
    ir_reg == IR_PRG_DONE;
  wire ir_ok = ir_common || (ENHANCED && ir_enh) ||
    (!ENHANCED && ir_reg == IR_SIGN); // R6 R11 R12
  wire [3:0] cur_ir = ir_ok ? ir_reg : IR_BYPASS; // R16
  wire prog_mode = cur_ir == IR_PRG_ENTER || cur_ir == IR_PRG_ADAPT ||
    cur_ir == IR_PRG_CONST || cur_ir == IR_PRG_VERIFY ||
    cur_ir == IR_PRG_DONE; // R1 R13
  wire bs_ir = cur_ir == IR_EXTEST || cur_ir == IR_SAMPLE;
  wire pins_ok = prog_done_reg || !ENHANCED;

  // R15
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_reg <= TLR;
    end else if (user_io) begin
      tap_reg <= TLR; // R14
    end else if (tck_rise) begin
      tap_reg <= tap_step(tap_reg, scan_s2_reg.tms);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_sr_reg <= IR_CAPTURE;
      ir_reg <= IR_IDCODE;
    end else if (tap_reg == TLR) begin
      ir_reg <= IR_IDCODE;
    end else if (tck_rise) begin
      if (tap_reg == CAP_IR) ir_sr_reg <= IR_CAPTURE;
      if (tap_reg == SH_IR) ir_sr_reg <= {tdi, ir_sr_reg[3:1]}; // R15
      if (tap_reg == UPD_IR) ir_reg <= ir_sr_reg;
    end
  end

  // capture values per selected data register
  always_comb begin
    dr_cap = '0;
    case (cur_ir)
      IR_EXTEST, IR_SAMPLE:
        dr_cap[BW-1:0] = {pin_s2_reg, core_out, core_oe}; // R7 R8
      IR_IDCODE: dr_cap[31:0] = IDCODE_VAL; // R10
      IR_USERCODE, IR_SIGN: dr_cap[31:0] = conf_reg; // R11 R12
      IR_PRG_VERIFY: dr_cap[31:0] = conf_reg; // R4
      default: dr_cap = '0; // R9
    endcase
  end

  // lsb leaves first, tdi enters at the top of the active length
  always_comb begin
    logic [SW-1:0] tmp;
    tmp = {1'b0, dr_sr_reg[SW-1:1]};
    dr_sh = tmp;
    for (int i = 0; i < SW; i++) begin
      if (i == dr_len(cur_ir) - 1) dr_sh[i] = tdi; // R9 R15
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_sr_reg <= '0;
    end else if (tck_rise && tap_reg == CAP_DR) begin
      dr_sr_reg <= dr_cap;
    end else if (tck_rise && tap_reg == SH_DR) begin
      dr_sr_reg <= dr_sh;
    end
  end

  // update stage; the config word stands in for the nonvolatile array
  wire upd_dr = tck_rise && tap_reg == UPD_DR;
  wire prg_load = cur_ir == IR_PRG_ADAPT || cur_ir == IR_PRG_CONST;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bsr_reg <= '0;
      conf_reg <= CONF_RST;
      prog_done_reg <= DONE_RST;
    end else begin
      if (upd_dr && bs_ir) bsr_reg <= dr_sr_reg[BW-1:0]; // R7 R8
      if (upd_dr && prg_load) conf_reg <= dr_sr_reg[31:0]; // R5 R13
      if (tck_rise && tap_reg == UPD_IR && ir_sr_reg == IR_PRG_ENTER)
        prog_done_reg <= 1'b0; // R3
      else if (upd_dr && cur_ir == IR_PRG_DONE && dr_sr_reg[0])
        prog_done_reg <= 1'b1; // R3
    end
  end

  // tdo changes on the falling tck edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (user_io) begin
      tdo_reg <= ctrl_reg[CTRL_TDO_VAL]; // R14
      tdo_oe_reg <= ctrl_reg[CTRL_TDO_OE];
    end else if (tck_fall) begin
      tdo_reg <= (tap_reg == SH_IR) ? ir_sr_reg[0] : dr_sr_reg[0];
      tdo_oe_reg <= tap_reg == SH_IR || tap_reg == SH_DR;
    end
  end

  // pin control: programming > external test > core
  always_comb begin
    pin_out_next = core_out;
    pin_oe_next = core_oe & {NPIN{pins_ok}}; // R3
    pin_pu_next = '0;
    if (prog_mode) begin
      pin_out_next = '0;
      pin_oe_next = '0; // R2
      pin_pu_next = '1; // R2
    end else if (cur_ir == IR_EXTEST) begin
      pin_out_next = bsr_reg[2*NPIN-1:NPIN]; // R8
      pin_oe_next = bsr_reg[NPIN-1:0]; // R8
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      pin_pu_reg <= '0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      pin_pu_reg <= pin_pu_next;
    end
  end

  // ahb-lite slave, zero wait states, always OKAY
  wire ahb_go = hsel && htrans[1] && hready;
  wire [31:0] stat_word = {16'h0000, 4'(tap_reg), ir_reg, 3'h0,
    scan_s2_reg.tdi, scan_s2_reg.tms, scan_s2_reg.tck,
    prog_mode, prog_done_reg};
  wire [31:0] rd_mux =
    (haddr == OFS_CTRL) ? {29'h0, ctrl_reg} :
    (haddr == OFS_STAT) ? stat_word :
    (haddr == OFS_CONF) ? conf_reg :
    (haddr == OFS_IDR) ? IDCODE_VAL : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= '0;
      ctrl_reg <= CTRL_RST;
    end else begin
      wr_pend_reg <= ahb_go && hwrite;
      wr_addr_reg <= haddr;
      hrdata_reg <= (ahb_go && !hwrite) ? rd_mux : 32'h0000_0000;
      if (wr_pend_reg && wr_addr_reg == OFS_CTRL)
        ctrl_reg <= hwdata[2:0]; // R14
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tdo_out = tdo_reg;
  assign tdo_oe = tdo_oe_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign pin_pullup = pin_pu_reg;

  property p_prog_hiz;
    @(posedge hclk) disable iff (!hresetn)
    prog_mode |=> (pin_oe == '0) && (&pin_pullup);
  endproperty
  a_prog_hiz: assert property (p_prog_hiz) // R2
    else $error("user pin driven during programming");

  property p_done_gate;
    @(posedge hclk) disable iff (!hresetn)
    (ENHANCED && !prog_done_reg && cur_ir != IR_EXTEST) |=> pin_oe == '0;
  endproperty
  a_done_gate: assert property (p_done_gate) // R3
    else $error("pin driven before completion flag");

  property p_bypass_bit;
    @(posedge hclk) disable iff (!hresetn)
    (tck_rise && tap_reg == SH_DR && cur_ir == IR_BYPASS)
      |=> dr_sr_reg[0] == $past(tdi);
  endproperty
  a_bypass_bit: assert property (p_bypass_bit) // R9
    else $error("bypass is not one bit long");

  property p_unknown_cap;
    @(posedge hclk) disable iff (!hresetn)
    (tck_rise && tap_reg == CAP_DR && !ir_ok) |=> dr_sr_reg[0] == 1'b0;
  endproperty
  a_unknown_cap: assert property (p_unknown_cap) // R16
    else $error("unknown instruction did not select bypass");

  property p_id_cap;
    @(posedge hclk) disable iff (!hresetn)
    (tck_rise && tap_reg == CAP_DR && ir_reg == IR_IDCODE)
      |=> dr_sr_reg[31:0] == IDCODE_VAL;
  endproperty
  a_id_cap: assert property (p_id_cap) // R10
    else $error("identification not captured");

  property p_user_cap;
    @(posedge hclk) disable iff (!hresetn)
    (ENHANCED && tck_rise && tap_reg == CAP_DR && ir_reg == IR_USERCODE)
      |=> dr_sr_reg[31:0] == $past(conf_reg);
  endproperty
  a_user_cap: assert property (p_user_cap) // R11
    else $error("user code not captured");

  property p_extest_drive;
    @(posedge hclk) disable iff (!hresetn)
    (cur_ir == IR_EXTEST) |=> pin_out == $past(bsr_reg[2*NPIN-1:NPIN]);
  endproperty
  a_extest_drive: assert property (p_extest_drive) // R8
    else $error("external test pattern not on pins");

  property p_tlr_hold;
    @(posedge hclk) disable iff (!hresetn)
    (tck_rise && tap_reg == TLR && !user_io) |=>
      tap_reg == ($past(scan_s2_reg.tms) ? TLR : RTI);
  endproperty
  a_tlr_hold: assert property (p_tlr_hold) // R15
    else $error("controller left reset state wrongly");

  property p_user_io;
    @(posedge hclk) disable iff (!hresetn)
    user_io |=> tap_reg == TLR && tdo_out == $past(ctrl_reg[CTRL_TDO_VAL]);
  endproperty
  a_user_io: assert property (p_user_io) // R14
    else $error("scan pins not released to user");

  property p_const_base;
    @(posedge hclk) disable iff (!hresetn)
    (!ENHANCED && ir_reg == IR_PRG_CONST) |-> !prog_mode;
  endproperty
  a_const_base: assert property (p_const_base) // R6
    else $error("base variant accepted constant method");

  c_extest: cover property (@(posedge hclk) disable iff (!hresetn)
    upd_dr && cur_ir == IR_EXTEST);
  c_done: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(prog_done_reg));
  c_prog: cover property (@(posedge hclk) disable iff (!hresetn)
    upd_dr && prg_load);
  c_id_shift: cover property (@(posedge hclk) disable iff (!hresetn)
    tck_fall && tap_reg == SH_DR && cur_ir == IR_IDCODE);
endmodule : jbs_port

// ==== verif/jbs_prog_model.sv ====
// scan programmer model: drives tck, tms and tdi, reads tdo
// assumes the bench calls one task at a time; tck idles low
module jbs_prog_model (
  // scan pins towards the device
  output jbs_pkg::jbs_scan_t scan,
  // serial data back from the device
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import jbs_pkg::*;

  logic tdo_last;

  initial begin
    scan = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
    tdo_last = 1'b0;
  end

  // one 160 ns tck period; tdo read just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    scan.tms = tms;
    scan.tdi = tdi;
    #77;
    // undriven line must not look like the last value
    tdo = tdo_oe ? tdo_out : ~tdo_last;
    tdo_last = tdo;
    scan.tck = 1'b1;
    #80;
    scan.tck = 1'b0;
    #3;
  endtask : tick

  task automatic to_idle();
    logic t;
    repeat (5) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask : to_idle

  // idle, one ir or dr scan of n bits, back to idle
  task automatic scan_reg(input logic ir, input int n,
                          input logic [31:0] din, output logic [31:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, 1'b0, t);
    if (ir) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
    tick(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask : scan_reg
endmodule : jbs_prog_model

// ==== verif/jbs_port_tb.sv ====
// self-checking bench of the scan and programming port
// assumes this bench is the only ahb master; programmer model on scan pins
module jbs_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import jbs_pkg::*;

  localparam int NP = 8;
  localparam logic [31:0] ID_VAL = 32'h1357_9BDF; // arbitrary value
  localparam logic [31:0] CFG_A = 32'hC3A5_0F96;
  localparam logic [31:0] CFG_B = 32'h1234_ABCD;
  localparam logic [31:0] BYP = 32'h0000_004A;

  typedef struct {
    logic [3:0] code;
    int n;
    logic [31:0] din;
    logic [31:0] exp;
  } jbs_row_t;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tdo_out, tdo_oe;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NP-1:0] pin_in, core_out, core_oe, pin_out, pin_oe, pin_pullup;
  jbs_scan_t scan;
  int fail_count, tests_run;
  jbs_row_t rows [6];
  logic tdo_out_b, tdo_oe_b, use_b;
  logic [NP-1:0] pin_oe_b;
  // programmer listens to either variant
  wire tdo_m = use_b ? tdo_out_b : tdo_out;
  wire tdo_oe_m = use_b ? tdo_oe_b : tdo_oe;

  jbs_port #(.NPIN(NP), .ENHANCED(1'b1), .IDCODE_VAL(ID_VAL)) jbs_port_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scan_in(scan), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup)
  );

  // base variant on the same scan and bus lines
  jbs_port #(.NPIN(NP), .ENHANCED(1'b0), .IDCODE_VAL(ID_VAL)) jbs_port_b_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
    .scan_in(scan), .tdo_out(tdo_out_b), .tdo_oe(tdo_oe_b),
    .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
    .pin_out(), .pin_oe(pin_oe_b), .pin_pullup()
  );

  jbs_prog_model jbs_prog_model_i (
    .scan(scan), .tdo_out(tdo_m), .tdo_oe(tdo_oe_m)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // single word transfer; waits on hready, never on a cycle count
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, '0, r);
    chk(r & m, e);
  endtask : rd_chk

  task automatic ir(input logic [3:0] c);
    logic [31:0] r;
    jbs_prog_model_i.scan_reg(1'b1, IR_W, {28'h0, c}, r);
    chk(r, 32'h0000_0001);
  endtask : ir

  task automatic dr(input int n, input logic [31:0] din);
    jbs_prog_model_i.scan_reg(1'b0, n, din, d);
  endtask : dr

  // load a word, then read it back before going on
  task automatic prog_word(input logic [3:0] c, input logic [31:0] w);
    ir(c);
    dr(32, w);
    ir(IR_PRG_VERIFY);
    dr(32, 32'h0);
    chk(d, w);
  endtask : prog_word

  initial begin
    #600us;
    fail_count++;
    end_of_test();
  end

  initial begin
    fail_count = 0;
    tests_run = 0;
    use_b = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    pin_in = 8'h3C;
    core_out = 8'h96;
    core_oe = 8'hF0;
    rows = '{
      '{IR_IDCODE, 32, 32'hFFFF_FFFF, ID_VAL},
      '{IR_BYPASS, 8, 32'h0000_00A5, BYP},
      '{4'hC, 8, 32'h0000_00A5, BYP},
      '{IR_SIGN, 8, 32'h0000_00A5, BYP},
      '{IR_USERCODE, 32, 32'h0, CFG_A},
      '{IR_SAMPLE, 24, 32'h0000_C30F, 32'h003C_96F0}
    };
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({hresp, pin_out, pin_oe, pin_pullup}, {1'b0, 24'h96_F000});
    rd_chk(OFS_STAT, 32'hFFFF_FF03, 32'h0000_0201);
    jbs_prog_model_i.to_idle();
    ir(IR_PRG_ENTER);
    chk({pin_oe, pin_pullup}, 32'h0000_00FF);
    rd_chk(OFS_STAT, 32'h0000_0003, 32'h0000_0002);
    // base variant refuses the constant method and leaves programming
    ir(IR_PRG_CONST);
    chk({pin_oe_b, pin_oe}, {core_oe, 8'h00});
    prog_word(IR_PRG_CONST, CFG_B);
    prog_word(IR_PRG_ADAPT, CFG_A);
    chk(pin_pullup, 8'hFF);
    // interrupted: flag still clear, no pin may drive
    ir(IR_BYPASS);
    chk(pin_oe, 8'h00);
    rd_chk(OFS_CONF, 32'hFFFF_FFFF, CFG_A);
    ir(IR_PRG_DONE);
    dr(32, 32'h1);
    ir(IR_BYPASS);
    chk({pin_out, pin_oe}, {core_out, core_oe});
    rd_chk(OFS_STAT, 32'h0000_0003, 32'h0000_0001);
    foreach (rows[i]) begin
      ir(rows[i].code);
      dr(rows[i].n, rows[i].din);
      chk(d, rows[i].exp);
    end
    // base variant answers the signature code with its config word
    use_b = 1'b1;
    ir(IR_SIGN);
    dr(32, 32'h0);
    chk(d, CFG_A);
    use_b = 1'b0;
    // sample left a preloaded pattern for external test
    ir(IR_EXTEST);
    chk({pin_out, pin_oe}, 32'h0000_C30F);
    dr(24, 32'h0000_5AFF);
    chk(d, 32'h003C_96F0);
    chk({pin_out, pin_oe}, 32'h0000_5AFF);
    ir(IR_BYPASS);
    ahb(1'b1, OFS_CTRL, 32'h0000_0007, d);
    rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0007);
    chk({tdo_oe, tdo_out}, 32'h0000_0003);
    jbs_prog_model_i.scan_reg(1'b1, IR_W, 32'h2, d);
    rd_chk(OFS_STAT, 32'h0000_F000, 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h0000_0001, d);
    // tdo enable follows the control word one edge later
    repeat (2) @(posedge hclk);
    chk(tdo_oe, 1'b0);
    ahb(1'b1, OFS_CTRL, 32'h0, d);
    ahb(1'b1, OFS_IDR, 32'h0, d);
    rd_chk(OFS_IDR, 32'hFFFF_FFFF, ID_VAL);
    rd_chk(32'h0000_0010, 32'hFFFF_FFFF, 32'h0);
    // second reset in mid-run
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rd_chk(OFS_STAT, 32'hFFFF_FF03, 32'h0000_0201);
    rd_chk(OFS_CONF, 32'hFFFF_FFFF, CONF_RST);
    end_of_test();
  end
endmodule : jbs_port_tb
